// [cam_capture_ctrl.sv]
// Trigger, exposure, status outputs, events and pixel path of the camera
`timescale 1ns/1ps
module cam_capture_ctrl
  import cam_pkg::*;
#(
  parameter bit LARGE_SENSOR = 1'b0
)
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic                   i_trig_pin,
  input  wire logic                   i_trig_high_active,
  input  wire logic                   i_host_trig,
  input  wire logic [1:0]             i_trig_mode,
  input  wire logic [DELAY_CNT_W-1:0] i_trig_delay_us,
  input  wire logic [DELAY_CNT_W-1:0] i_exposure_us,
  input  wire logic [BURST_W-1:0]     i_burst_count,
  input  wire logic                   i_seq_enable,
  input  wire logic [SET_W-1:0]       i_seq_last,
  input  wire logic                   i_readout_done,
  input  wire logic                   i_xfer_done,
  input  wire logic [DELAY_CNT_W-1:0] i_strobe_delay_us,
  input  wire logic [DELAY_CNT_W-1:0] i_strobe_width_us,
  input  wire logic [GPIO_N*3-1:0]    i_gpio_sel,
  input  wire logic [GPIO_N-1:0]      i_user_level,
  input  wire logic [GEO_W-1:0]       i_win_width,
  input  wire logic [GEO_W-1:0]       i_win_height,
  input  wire logic [GEO_W-1:0]       i_window_h_start,
  input  wire logic [GEO_W-1:0]       i_window_v_start,
  input  wire logic                   i_flip_h,
  input  wire logic                   i_flip_v,
  input  wire logic [2:0]             i_pattern,
  input  wire logic                   i_lut_we,
  input  wire logic [PIX_W-1:0]       i_lut_waddr,
  input  wire logic [PIX_W-1:0]       i_lut_wdata,
  input  wire logic                   i_pix_valid,
  input  wire logic [PIX_W-1:0]       i_pix_data,
  input  wire logic [GEO_W-1:0]       i_pix_x,
  input  wire logic [GEO_W-1:0]       i_pix_y,
  output logic [GPIO_N-1:0]           o_gpio,
  output logic                        o_trigger_accepted_event,
  output logic                        o_trigger_rejected_event,
  output logic                        o_trigger_wait_event,
  output logic                        o_transfer_begin_event,
  output logic                        o_transfer_finish_event,
  output logic                        o_exposure_begin_event,
  output logic                        o_exposure_finish_event,
  output logic                        o_strobe_timer_begin_event,
  output logic                        o_strobe_timer_finish_event,
  output logic [SET_W-1:0]            o_stored_setting_set,
  output logic [GEO_W-1:0]            o_win_width,
  output logic [GEO_W-1:0]            o_win_height,
  output logic [GEO_W-1:0]            o_window_h_start,
  output logic [GEO_W-1:0]            o_window_v_start,
  output logic                        o_win_error,
  output logic [GEO_W-1:0]            o_read_x,
  output logic [GEO_W-1:0]            o_read_y,
  output logic                        o_pix_valid,
  output logic [PIX_W-1:0]            o_pix_data
);
  import cam_pkg::*;

  // ---------------------------------------------------------------
  // Trigger input synchroniser and polarity
  // ---------------------------------------------------------------
  logic [2:0] trig_sync;
  logic       trig_raw, trig_raw_d;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) trig_sync <= 3'h0;
    else       trig_sync <= {trig_sync[1:0], i_trig_pin};
  end
  // Pin level moves when stages two and three agree; edges use the pin level, so a
  // low-active setup never sees a false trigger when the idle-high pin settles after reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) trig_raw <= 1'b0;
    else if (trig_sync[1] == trig_sync[2])
      trig_raw <= trig_sync[2];
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) trig_raw_d <= 1'b0;
    else       trig_raw_d <= trig_raw;
  end
  wire trig_level = trig_raw ~^ i_trig_high_active;
  wire pin_edge   = (trig_raw != trig_raw_d) && (trig_raw == i_trig_high_active);
  wire host_ok   = i_host_trig && (i_trig_mode == MODE_SETTING);
  wire trig_req  = pin_edge || host_ok;

  // ---------------------------------------------------------------
  // Capture sequencer
  // ---------------------------------------------------------------
  cap_state_type          state, next_state;
  logic [7:0]             tick;
  logic [DELAY_CNT_W-1:0] us;
  logic [BURST_W-1:0]     frames_left;
  logic                   exp_pulse;
  wire  waiting    = (state == ST_WAIT);
  wire  accept     = waiting && trig_req;
  wire  reject     = !waiting && trig_req;
  wire  tick_hit   = (tick == 8'(US_CYCLES - 1));
  wire  delay_hit  = tick_hit && (us + 1 >= i_trig_delay_us);
  wire  expo_hit   = tick_hit && (us + 1 >= i_exposure_us);
  wire  zero_delay = (i_trig_delay_us == '0);
  wire  expo_end   = exp_pulse ? !trig_level : expo_hit;
  wire  more_burst = (i_trig_mode == MODE_BURST) && (frames_left > 8'h01);

  // Next state; zero delay goes straight to exposure
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT:    if (accept) next_state = zero_delay ? ST_EXPOSE : ST_DELAY;
      ST_DELAY:   if (delay_hit) next_state = ST_EXPOSE;
      ST_EXPOSE:  if (expo_end) next_state = ST_READOUT;
      ST_READOUT: if (i_readout_done) next_state = ST_XFER;
      ST_XFER:    if (i_xfer_done) next_state = more_burst ? ST_EXPOSE : ST_WAIT;
      default:    next_state = ST_WAIT;
    endcase
  end

  // State, microsecond counter and burst count; counter restarts per phase
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_WAIT; tick <= 8'h00; us <= '0;
      frames_left <= '0; exp_pulse <= 1'b0;
    end else begin
      state <= next_state;
      tick  <= (next_state != state || tick_hit) ? 8'h00 : tick + 8'h01;
      us    <= (next_state != state) ? '0 : (tick_hit ? us + 1 : us);
      if (accept) begin
        frames_left <= (i_burst_count == '0) ? 8'h01 : i_burst_count;
        exp_pulse   <= (i_trig_mode == MODE_PULSE);
      end else if (state == ST_XFER && i_xfer_done) begin
        frames_left <= frames_left - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stored setting set stepping
  // ---------------------------------------------------------------
  wire frame_end = (state == ST_XFER) && i_xfer_done;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) o_stored_setting_set <= '0;
    else if (!i_seq_enable) o_stored_setting_set <= '0;
    else if (frame_end)
      o_stored_setting_set <= (o_stored_setting_set == i_seq_last) ? '0
                              : o_stored_setting_set + 1'b1;
  end

  // ---------------------------------------------------------------
  // Event pulses
  // ---------------------------------------------------------------
  wire exp_start = (next_state == ST_EXPOSE) && (state != ST_EXPOSE);
  wire exp_stop  = (state == ST_EXPOSE) && (next_state != ST_EXPOSE);
  logic strobe_active, strobe_begin, strobe_finish;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_trigger_accepted_event <= 1'b0; o_trigger_rejected_event <= 1'b0;
      o_trigger_wait_event <= 1'b0; o_transfer_begin_event <= 1'b0;
      o_transfer_finish_event <= 1'b0; o_exposure_begin_event <= 1'b0;
      o_exposure_finish_event <= 1'b0; o_strobe_timer_begin_event <= 1'b0;
      o_strobe_timer_finish_event <= 1'b0;
    end else begin
      o_trigger_accepted_event    <= accept;
      o_trigger_rejected_event    <= reject;
      o_trigger_wait_event        <= (next_state == ST_WAIT) && !waiting;
      o_transfer_begin_event      <= (next_state == ST_XFER) && state != ST_XFER;
      o_transfer_finish_event     <= frame_end;
      o_exposure_begin_event      <= exp_start;
      o_exposure_finish_event     <= exp_stop;
      o_strobe_timer_begin_event  <= strobe_begin;
      o_strobe_timer_finish_event <= strobe_finish;
    end
  end

  // ---------------------------------------------------------------
  // Strobe timer, started at exposure start
  // ---------------------------------------------------------------
  cam_delay_timer u_strobe (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_start    (exp_start),
    .i_delay_us (i_strobe_delay_us),
    .i_width_us (i_strobe_width_us),
    .o_active   (strobe_active),
    .o_begin    (strobe_begin),
    .o_finish   (strobe_finish)
  );

  // ---------------------------------------------------------------
  // Status outputs, one multiplexer per channel
  // ---------------------------------------------------------------
  wire st_expose = (state == ST_EXPOSE);
  wire st_frame  = (state == ST_EXPOSE) || (state == ST_READOUT);
  wire st_xfer   = (state == ST_XFER);
  genvar g;
  generate
    for (g = 0; g < GPIO_N; g++) begin : g_gpio
      wire [2:0] sel = i_gpio_sel[g*3 +: 3];
      wire       src = (sel == SRC_STROBE) ? strobe_active :
                       (sel == SRC_USER)   ? i_user_level[g] :
                       (sel == SRC_EXPOSE) ? st_expose :
                       (sel == SRC_FRAME)  ? st_frame :
                       (sel == SRC_XFER)   ? st_xfer :
                       (sel == SRC_WAIT)   ? waiting : 1'b0;
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) o_gpio[g] <= 1'b0;
        else       o_gpio[g] <= src;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Readout window check and freeze
  // ---------------------------------------------------------------
  localparam logic [GEO_W-1:0] max_w = LARGE_SENSOR ? MAX_W_LARGE : MAX_W_SMALL;
  localparam logic [GEO_W-1:0] max_h = LARGE_SENSOR ? MAX_H_LARGE : MAX_H_SMALL;
  wire [GEO_W:0]   h_end = {1'b0, i_win_width} + {1'b0, i_window_h_start};
  wire [GEO_W:0]   v_end = {1'b0, i_win_height} + {1'b0, i_window_v_start};
  wire win_ok = (i_win_width >= WIN_MIN_W) && (i_win_height >= WIN_MIN_H)
             && (i_win_width[H_UNIT_LSB-1:0] == '0)
             && (i_win_height[V_UNIT_LSB-1:0] == '0)
             && (i_window_h_start[H_UNIT_LSB-1:0] == '0)
             && (i_window_v_start[V_UNIT_LSB-1:0] == '0)
             && (h_end <= {1'b0, max_w}) && (v_end <= {1'b0, max_h});
  // Only legal settings are taken, and only between frames, never in sequence mode
  wire win_load = win_ok && waiting && !i_seq_enable;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_win_width <= max_w; o_win_height <= max_h;
      o_window_h_start <= '0; o_window_v_start <= '0; o_win_error <= 1'b0;
    end else begin
      o_win_error <= !win_ok;
      if (win_load) begin
        o_win_width      <= i_win_width;
        o_win_height     <= i_win_height;
        o_window_h_start <= i_window_h_start;
        o_window_v_start <= i_window_v_start;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pixel path: mirror addressing, pattern source, lookup table
  // ---------------------------------------------------------------
  wire [GEO_W-1:0] last_x = o_win_width - 1'b1;
  wire [GEO_W-1:0] last_y = o_win_height - 1'b1;
  wire [PIX_W-1:0] pat_pix =
      (i_pattern == PAT_BLACK) ? PIX_BLACK :
      (i_pattern == PAT_WHITE) ? PIX_WHITE :
      (i_pattern == PAT_HRAMP) ? {i_pix_x[7:0], 2'b00} :
      (i_pattern == PAT_VRAMP) ? {i_pix_y[7:0], 2'b00} : i_pix_data;
  logic [PIX_W-1:0] lut_out;
  logic             valid_d;
  cam_lut_mem u_lut (
    .i_mclk  (i_mclk),
    .i_we    (i_lut_we),
    .i_waddr (i_lut_waddr),
    .i_wdata (i_lut_wdata),
    .i_raddr (pat_pix),
    .o_rdata (lut_out)
  );
  // Mirror applied as a read address for the frame store upstream
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_read_x <= '0; o_read_y <= '0; valid_d <= 1'b0;
    end else begin
      o_read_x <= i_flip_h ? last_x - i_pix_x : i_pix_x;
      o_read_y <= i_flip_v ? last_y - i_pix_y : i_pix_y;
      valid_d  <= i_pix_valid;
    end
  end
  assign o_pix_valid = valid_d;
  assign o_pix_data  = lut_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_reject;
    @(posedge i_mclk) disable iff (i_rst) reject |=> o_trigger_rejected_event;
  endproperty
  a_reject: assert property (p_reject) else $error("rejected trigger not reported");
  property p_no_host_pulse;
    @(posedge i_mclk) disable iff (i_rst)
      (waiting && i_host_trig && !pin_edge && i_trig_mode == MODE_PULSE) |=> $stable(state);
  endproperty
  a_no_host_pulse: assert property (p_no_host_pulse) else $error("host trigger taken");
  property p_accept_expose;
    @(posedge i_mclk) disable iff (i_rst)
      (accept && zero_delay) |=> (state == ST_EXPOSE);
  endproperty
  a_accept_expose: assert property (p_accept_expose) else $error("no immediate exposure");
  property p_pulse_end;
    @(posedge i_mclk) disable iff (i_rst)
      (st_expose && exp_pulse && !trig_level) |=> (state == ST_READOUT);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse exposure overrun");
  property p_frame_cover;
    @(posedge i_mclk) disable iff (i_rst) st_expose |-> st_frame;
  endproperty
  a_frame_cover: assert property (p_frame_cover) else $error("frame active gap");
  property p_seq_freeze;
    @(posedge i_mclk) disable iff (i_rst) i_seq_enable |=> $stable(o_win_width);
  endproperty
  a_seq_freeze: assert property (p_seq_freeze) else $error("window changed");
  property p_win_bound;
    @(posedge i_mclk) disable iff (i_rst) o_win_width <= max_w && o_win_height <= max_h;
  endproperty
  a_win_bound: assert property (p_win_bound) else $error("window above maximum");
  property p_burst_more;
    @(posedge i_mclk) disable iff (i_rst)
      (frame_end && more_burst) |=> (state == ST_EXPOSE);
  endproperty
  a_burst_more: assert property (p_burst_more) else $error("burst ended early");
  c_burst:  cover property (@(posedge i_mclk) frame_end && more_burst);
  c_reject: cover property (@(posedge i_mclk) reject);
  c_strobe: cover property (@(posedge i_mclk) strobe_finish);
endmodule : cam_capture_ctrl

// [cam_delay_timer.sv]
// Programmable delay-then-width pulse timer in microseconds
`timescale 1ns/1ps
module cam_delay_timer
  import cam_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic                   i_start,
  input  wire logic [DELAY_CNT_W-1:0] i_delay_us,
  input  wire logic [DELAY_CNT_W-1:0] i_width_us,
  output logic                        o_active,
  output logic                        o_begin,
  output logic                        o_finish
);
  // ---------------------------------------------------------------
  // Microsecond tick and phase counters
  // ---------------------------------------------------------------
  logic [7:0]             tick;
  logic [DELAY_CNT_W-1:0] us;
  logic                   in_delay;
  wire                    tick_hit = (tick == 8'(US_CYCLES - 1));
  wire                    d_done   = in_delay && tick_hit && (us + 1 >= i_delay_us);
  wire                    w_done   = o_active && tick_hit && (us + 1 >= i_width_us);

  // Zero width makes no pulse at all, as a strobe of length 0 should
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tick <= 8'h00; us <= '0; in_delay <= 1'b0;
      o_active <= 1'b0; o_begin <= 1'b0; o_finish <= 1'b0;
    end else begin
      o_begin  <= 1'b0;
      o_finish <= 1'b0;
      tick     <= (i_start || tick_hit) ? 8'h00 : tick + 8'h01;
      if (i_start) begin
        us <= '0;
        in_delay <= (i_delay_us != '0);
        o_active <= (i_delay_us == '0) && (i_width_us != '0);
        o_begin  <= (i_delay_us == '0) && (i_width_us != '0);
      end else if (d_done) begin
        us <= '0; in_delay <= 1'b0;
        o_active <= (i_width_us != '0);
        o_begin  <= (i_width_us != '0);
      end else if (w_done) begin
        o_active <= 1'b0; o_finish <= 1'b1;
      end else if (tick_hit) begin
        us <= us + 1;
      end
    end
  end
endmodule : cam_delay_timer

// [cam_far_side.sv]
// Sensor readout and USB transfer side that answers the capture block
`timescale 1ns/1ps
module cam_far_side #(
  parameter int LAT = 20
)(
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_exp_end,
  input  wire logic i_xfer_begin,
  output logic      o_readout_done,
  output logic      o_xfer_done
);
  int rd_cnt;
  int xf_cnt;
  // Reload on each event; the done strobe lasts one cycle so it can never be seen twice
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_cnt <= 0;
      xf_cnt <= 0;
    end else begin
      rd_cnt <= i_exp_end ? LAT : (rd_cnt > 0 ? rd_cnt - 1 : 0);
      xf_cnt <= i_xfer_begin ? LAT : (xf_cnt > 0 ? xf_cnt - 1 : 0);
    end
  end
  assign o_readout_done = (rd_cnt == 1);
  assign o_xfer_done    = (xf_cnt == 1);
endmodule : cam_far_side

// [cam_lut_mem.sv]
// 10-bit in, 10-bit out pixel lookup memory with registered read
`timescale 1ns/1ps
module cam_lut_mem
  import cam_pkg::*;
#(
  parameter int DW = PIX_W
)
(
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [DW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [DW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<DW)-1];

  // Host loads the curve, pixel path reads one entry per clock
  always_ff @(posedge i_mclk) begin
    if (i_we) mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule : cam_lut_mem

// [cam_pkg.sv]
// Shared constants and types for the capture control block
package cam_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int DELAY_MAX_US     = 2000000;
  localparam int US_CYCLES        = CLK_MHZ;
  localparam int DELAY_CNT_W      = 32;

  // ---------------------------------------------------------------
  // Window geometry
  // ---------------------------------------------------------------
  localparam int GEO_W            = 12;
  localparam logic [GEO_W-1:0] WIN_MIN_W   = 12'h040;
  localparam logic [GEO_W-1:0] WIN_MIN_H   = 12'h040;
  localparam logic [GEO_W-1:0] MAX_W_SMALL = 12'h800;
  localparam logic [GEO_W-1:0] MAX_H_SMALL = 12'h602;
  localparam logic [GEO_W-1:0] MAX_W_LARGE = 12'h990;
  localparam logic [GEO_W-1:0] MAX_H_LARGE = 12'h800;
  localparam int H_UNIT_LSB       = 3;
  localparam int V_UNIT_LSB       = 1;

  // ---------------------------------------------------------------
  // Pixels, burst, sets
  // ---------------------------------------------------------------
  localparam int PIX_W            = 10;
  localparam int BURST_W          = 8;
  localparam int SET_W            = 4;
  localparam logic [PIX_W-1:0] PIX_WHITE = 10'h3fc;
  localparam logic [PIX_W-1:0] PIX_BLACK = 10'h000;
  localparam int GPIO_N           = 2;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SETTING = 2'h0;
  localparam logic [1:0] MODE_PULSE   = 2'h1;
  localparam logic [1:0] MODE_BURST   = 2'h2;

  localparam logic [2:0] SRC_STROBE   = 3'h0;
  localparam logic [2:0] SRC_USER     = 3'h1;
  localparam logic [2:0] SRC_EXPOSE   = 3'h2;
  localparam logic [2:0] SRC_FRAME    = 3'h3;
  localparam logic [2:0] SRC_XFER     = 3'h4;
  localparam logic [2:0] SRC_WAIT     = 3'h5;

  localparam logic [2:0] PAT_OFF      = 3'h0;
  localparam logic [2:0] PAT_BLACK    = 3'h1;
  localparam logic [2:0] PAT_WHITE    = 3'h2;
  localparam logic [2:0] PAT_HRAMP    = 3'h3;
  localparam logic [2:0] PAT_VRAMP    = 3'h4;

  typedef enum logic [2:0] {
    ST_WAIT, ST_DELAY, ST_EXPOSE, ST_READOUT, ST_XFER
  } cap_state_type;

endpackage : cam_pkg

// [camera_trigger_exposure_control_test.sv]
// Self-checking testbench for the capture control block
`timescale 1ns/1ps
module camera_trigger_exposure_control_test;
  import cam_pkg::*;
  typedef struct {logic [1:0] m; bit h; bit p; int len; int b; int n; int lo; int hi;} row_type;
  logic i_mclk=0, i_rst=1, i_trig_pin=0, i_trig_high_active=1, i_host_trig=0, i_seq_enable=0;
  logic i_readout_done, i_xfer_done, i_flip_h=0, i_flip_v=0, i_lut_we=0, i_pix_valid=0;
  logic [1:0] i_trig_mode=0, i_user_level=0, o_gpio;
  logic [2:0] i_pattern=0;
  logic [5:0] i_gpio_sel={SRC_WAIT, SRC_EXPOSE};
  logic [7:0] i_burst_count=1;
  logic [3:0] i_seq_last=0;
  logic [31:0] i_trig_delay_us=0, i_exposure_us=1, i_strobe_delay_us=0, i_strobe_width_us=1;
  logic [11:0] i_win_width=MAX_W_SMALL, i_win_height=MAX_H_SMALL, i_window_h_start=0;
  logic [11:0] i_window_v_start=0, i_pix_x=0, i_pix_y=0, o_win_width, o_win_height;
  logic [9:0] i_lut_waddr=PIX_WHITE, i_lut_wdata=PIX_WHITE, i_pix_data=0, o_pix_data;
  logic o_trigger_accepted_event, o_trigger_rejected_event, o_transfer_begin_event;
  logic o_exposure_begin_event, o_exposure_finish_event, o_win_error;
  logic o_trigger_wait_event, o_transfer_finish_event, o_strobe_timer_begin_event;
  logic o_strobe_timer_finish_event, o_pix_valid;
  logic [11:0] o_read_x, o_read_y, o_window_h_start, o_window_v_start;
  logic [3:0] o_stored_setting_set;
  int fail_count=0, cmp_count=0, ne, nx, na, nr, nt, nf, nw, ns;
  row_type rows[5] = '{'{MODE_SETTING,1,1,0,1,1,250,252}, '{MODE_SETTING,0,0,8,1,1,250,252},
    '{MODE_PULSE,0,1,400,1,1,396,404}, '{MODE_BURST,0,0,8,3,3,750,756}, '{MODE_BURST,0,1,8,0,1,250,252}};
  cam_capture_ctrl u_cam_capture_ctrl (.i_mclk, .i_rst, .i_trig_pin, .i_trig_high_active,
    .i_host_trig, .i_trig_mode, .i_trig_delay_us, .i_exposure_us, .i_burst_count, .i_seq_enable,
    .i_seq_last, .i_readout_done, .i_xfer_done, .i_strobe_delay_us, .i_strobe_width_us,
    .i_gpio_sel, .i_user_level, .i_win_width, .i_win_height, .i_window_h_start,
    .i_window_v_start, .i_flip_h, .i_flip_v, .i_pattern, .i_lut_we, .i_lut_waddr, .i_lut_wdata,
    .i_pix_valid, .i_pix_data, .i_pix_x, .i_pix_y, .o_gpio, .o_trigger_accepted_event,
    .o_trigger_rejected_event, .o_trigger_wait_event, .o_transfer_begin_event,
    .o_transfer_finish_event, .o_exposure_begin_event, .o_exposure_finish_event,
    .o_strobe_timer_begin_event, .o_strobe_timer_finish_event, .o_stored_setting_set,
    .o_win_width, .o_win_height, .o_window_h_start, .o_window_v_start, .o_win_error,
    .o_read_x, .o_read_y, .o_pix_valid, .o_pix_data);
  cam_far_side u_cam_far_side (.i_mclk, .i_rst, .i_exp_end(o_exposure_finish_event),
    .i_xfer_begin(o_transfer_begin_event), .o_readout_done(i_readout_done),
    .o_xfer_done(i_xfer_done));
  // ----------------------------------------
  // Clock, event tallies and shared tasks
  // ----------------------------------------
  initial forever #2 i_mclk = ~i_mclk;
  // Tallies are sampled mid-cycle so registered outputs have settled
  always @(negedge i_mclk) begin
    ne += o_exposure_begin_event;
    nx += o_gpio[0];
    na += o_trigger_accepted_event;
    nr += o_trigger_rejected_event;
    nt += o_transfer_begin_event;
    nf += o_transfer_finish_event;
    nw += o_trigger_wait_event;
    ns += o_strobe_timer_begin_event + o_strobe_timer_finish_event;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Pin triggers only go out once trigger-wait shows, as the source must
  task trig(input bit h, input bit p, input int len, input int span);
    for (int k = 0; k < 8000 && o_gpio[1] !== 1'b1; k++) @(negedge i_mclk);
    if (o_gpio[1] !== 1'b1) begin fail_count++; final_report(); end
    {ne, nx, na, nr, nt, nf, nw, ns} = '0;
    if (h) i_host_trig = 1;
    else i_trig_pin = p;
    @(negedge i_mclk) i_host_trig = 0;
    repeat (len) @(negedge i_mclk);
    i_trig_pin = !p;
    repeat (span) @(negedge i_mclk);
  endtask : trig
  initial begin
    repeat (6) @(negedge i_mclk);
    i_rst = 0;
    chk("rst_w", o_win_width, MAX_W_SMALL);
    chk("rst_h", o_win_height, MAX_H_SMALL);
    foreach (rows[i]) begin
      {i_trig_mode, i_burst_count} = {rows[i].m, rows[i].b[7:0]};
      {i_trig_high_active, i_trig_pin} = {rows[i].p, !rows[i].p};
      // Idle level must settle through the synchroniser before the active edge
      repeat (8) @(negedge i_mclk);
      trig(rows[i].h, rows[i].p, rows[i].len, 2000);
      chk("exposures", ne, rows[i].n);
      chk("expose_len", nx >= rows[i].lo && nx <= rows[i].hi, 1);
      chk("accepted", na, 1);
      chk("xfer_begin", nt, rows[i].n);
      chk("xfer_end", nf, rows[i].n);
      chk("wait_ev", nw, 1);
    end
    i_trig_mode = MODE_SETTING;
    trig(1, 1, 0, 20);
    i_host_trig = 1;
    @(negedge i_mclk) i_host_trig = 0;
    repeat (1500) @(negedge i_mclk);
    chk("accepted_once", na, 1);
    chk("rejected", nr, 1);
    i_trig_mode = MODE_PULSE;
    trig(1, 1, 0, 600);
    chk("host_ignored", na + ne, 0);
    {i_trig_mode, i_trig_delay_us} = {MODE_SETTING, 32'd2};
    trig(1, 1, 0, 480);
    chk("delay_hold", ne, 0);
    repeat (40) @(negedge i_mclk);
    chk("delay_end", ne, 1);
    {i_trig_delay_us, i_gpio_sel} = {32'd0, SRC_WAIT, SRC_STROBE};
    trig(1, 1, 0, 1500);
    chk("strobe_len", nx >= 250 && nx <= 252, 1);
    chk("strobe_ev", ns, 2);
    {i_gpio_sel, i_user_level} = {SRC_WAIT, SRC_USER, 2'h1};
    {i_win_width, i_pattern, i_pix_valid, i_lut_we} = {12'h041, PAT_WHITE, 2'h3};
    {i_flip_h, i_flip_v, i_pix_x, i_pix_y} = {2'h3, 12'h005, 12'h002};
    repeat (3) @(negedge i_mclk);
    chk("user_out", o_gpio[0], 1);
    chk("win_bad", o_win_error, 1);
    chk("white", o_pix_data, PIX_WHITE);
    chk("pix_valid", o_pix_valid, 1);
    chk("flip_x", o_read_x, 12'h7fa);
    chk("flip_y", o_read_y, 12'h5ff);
    {i_win_width, i_window_h_start, i_win_height, i_window_v_start} =
      {12'h400, 12'h008, 12'h100, 12'h002};
    repeat (2) @(negedge i_mclk);
    chk("win_load", {o_win_error, o_win_width, o_window_h_start}, {1'b0, 12'h400, 12'h008});
    chk("win_v", {o_win_height, o_window_v_start}, {12'h100, 12'h002});
    // Sequence mode: window frozen, set index steps per frame and wraps after the last
    {i_seq_enable, i_seq_last, i_win_width, i_gpio_sel} = {1'b1, 4'h1, 12'h200, SRC_WAIT, SRC_FRAME};
    trig(1, 1, 0, 400);
    chk("seq_freeze", o_win_width, 12'h400);
    chk("seq_set", o_stored_setting_set, 1);
    chk("frame_len", nx >= 269 && nx <= 274, 1);
    i_gpio_sel = {SRC_WAIT, SRC_XFER};
    trig(1, 1, 0, 400);
    chk("seq_wrap", o_stored_setting_set, 0);
    chk("xfer_len", nx >= 20 && nx <= 23, 1);
    i_win_width = 12'h808;
    repeat (2) @(negedge i_mclk);
    chk("win_max", o_win_error, 1);
    final_report();
  end
endmodule : camera_trigger_exposure_control_test
